// ### logic/srxr_pkg.sv
// constants shared by the receive channel router and its sample fifo
// assumes an 8-bit register port and 32-bit serial slots
package srxr_pkg;
	// register offsets, channels 4 to 6
	localparam logic [7:0] CH4_OFFSET = 8'h2b;
	localparam logic [7:0] CH5_OFFSET = 8'h2c;
	localparam logic [7:0] CH6_OFFSET = 8'h2d;
	// values after reset
	localparam logic [7:0] CH4_RESET  = 8'h03;
	localparam logic [7:0] CH5_RESET  = 8'h04;
	localparam logic [7:0] CH6_RESET  = 8'h05;
	// writable bits; reserved bits are never stored
	localparam logic [7:0] CH4_MASK   = 8'h3f;
	localparam logic [7:0] CH56_MASK  = 8'h7f;
	// field positions
	localparam int CH4_ENABLE_POS = 5;
	localparam int SRC_LSB        = 5;
	localparam int SRC_MSB        = 6;
	localparam int SLOT_MSB       = 4;
	// serial framing and buffering
	localparam int SAMPLE_W       = 32;
	localparam logic [4:0] LAST_BIT = 5'h1f;
	localparam int HALF_SLOTS     = 16;
	localparam int NUM_CH         = 3;
	localparam int FIFO_DEPTH     = 8;
	localparam int FIFO_W         = SAMPLE_W + 2;
	localparam int SYNC_LEN       = 3;

	// normalised source of a channel
	typedef enum logic [1:0] {
		SRC_OFF    = 2'b00,
		SRC_SERIAL = 2'b01,
		SRC_ADC    = 2'b10,
		SRC_ICL    = 2'b11
	} srxr_src_t;
endpackage

// ### logic/srxr_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module srxr_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// handshakes are combinational, data comes straight from the flop array
	assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_data  = mem_reg[rd_reg];

	// storage, no reset needed on the data itself
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_reg] <= i_in_data;
		end
	end

	// pointers wrap because depth is a power of two
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + AW'(1);
			end
			if (pop) begin
				rd_reg <= rd_reg + AW'(1);
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // srxr_fifo

// ### logic/srxr_router.sv
// receive channel router for serial port channels 4 to 6
// assumes bclk, fsync and din arrive from pins; adc and link samples are on i_clk
// Functional notes
// - bits 7-6 of the channel 4 register read as zero and are ignored.
// - channel 4 bit 5 enables the channel; when set its slot feeds dac channel 4.
// - slot values 0-15 pick tdm slot 0-15, or left slot 0-15 in i2s or lj.
// - slot values 16-31 pick tdm slot 16-31, or right slot value minus 16 in i2s or lj.
// - the slot field sits in bits 4-0 and resets to 3, 4 and 5 for channels 4, 5, 6.
// - channel 5 source bits 6-5 pick off, dac data, adc 1 loopback, or reserved.
// - channel 6 source bits 6-5 reset to 0 and pick off, dac data, adc 2 loopback, link 1.
// - bit 7 of the channel 5 and 6 registers is reserved, read only and zero.
`timescale 1ns/1ps
module srxr_router (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	output logic [7:0]       o_reg_rdata,
	input  wire logic        i_fmt_tdm,
	input  wire logic        i_bclk,
	input  wire logic        i_fsync,
	input  wire logic        i_din,
	input  wire logic [31:0] i_adc1_sample,
	input  wire logic [31:0] i_adc2_sample,
	input  wire logic [31:0] i_icl_dev1_sample,
	output logic             o_dac_valid,
	input  wire logic        i_dac_ready,
	output logic [31:0]      o_dac_data,
	output logic [1:0]       o_dac_chan,
	output logic             o_overrun,
	input  wire logic        i_overrun_clr
);
	logic [7:0]  cfg_reg [srxr_pkg::NUM_CH];
	logic [2:0]  bclk_sync_reg;
	logic [2:0]  fs_sync_reg;
	logic [2:0]  din_sync_reg;
	logic        bclk_reg;
	logic        fs_reg;
	logic        din_reg;
	logic        fs_last_reg;
	logic        framed_reg;
	logic        half_reg;
	logic [4:0]  bit_reg;
	logic [4:0]  slot_reg;
	logic [30:0] shift_reg;
	logic [31:0] word_reg [srxr_pkg::NUM_CH];
	logic [2:0]  pend_reg;
	logic        bclk_rise;
	logic        frame_start;
	logic        right_start;
	logic        cap_ev;
	logic [4:0]  key;
	logic [31:0] serial_word;
	logic [2:0]  cap_hit;
	logic [2:0]  pop_sel;
	logic [1:0]  pop_idx;
	logic        fifo_ready;
	logic [33:0] fifo_out;

	// normalise each channel's selection to one source code
	function automatic srxr_pkg::srxr_src_t src_of(input int ch, input logic [7:0] cfg);
		logic [1:0] f;
		f = cfg[srxr_pkg::SRC_MSB:srxr_pkg::SRC_LSB];
		if (ch == 0) begin
			return cfg[srxr_pkg::CH4_ENABLE_POS] ? srxr_pkg::SRC_SERIAL : srxr_pkg::SRC_OFF;
		end
		if (ch == 1 && f == 2'h3) begin
			return srxr_pkg::SRC_OFF; // reserved code treated as off
		end
		return srxr_pkg::srxr_src_t'(f);
	endfunction

	// register port: reserved bits dropped on write, read back as zero
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cfg_reg[0] <= srxr_pkg::CH4_RESET;
			cfg_reg[1] <= srxr_pkg::CH5_RESET;
			cfg_reg[2] <= srxr_pkg::CH6_RESET;
		end else if (i_reg_wr) begin
			if (i_reg_addr == srxr_pkg::CH4_OFFSET) begin
				cfg_reg[0] <= i_reg_wdata & srxr_pkg::CH4_MASK;
			end
			if (i_reg_addr == srxr_pkg::CH5_OFFSET) begin
				cfg_reg[1] <= i_reg_wdata & srxr_pkg::CH56_MASK;
			end
			if (i_reg_addr == srxr_pkg::CH6_OFFSET) begin
				cfg_reg[2] <= i_reg_wdata & srxr_pkg::CH56_MASK;
			end
		end
	end

	// read data one cycle after the address; unmapped reads give zero
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 8'h00;
		end else begin
			unique case (i_reg_addr)
				srxr_pkg::CH4_OFFSET: o_reg_rdata <= cfg_reg[0];
				srxr_pkg::CH5_OFFSET: o_reg_rdata <= cfg_reg[1];
				srxr_pkg::CH6_OFFSET: o_reg_rdata <= cfg_reg[2];
				default:              o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// three-stage pin synchronisers; a level counts once stages 2 and 3 agree
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			bclk_sync_reg <= 3'h0;
			fs_sync_reg   <= 3'h0;
			din_sync_reg  <= 3'h0;
			bclk_reg      <= 1'b0;
			fs_reg        <= 1'b0;
			din_reg       <= 1'b0;
		end else begin
			bclk_sync_reg <= {bclk_sync_reg[1:0], i_bclk};
			fs_sync_reg   <= {fs_sync_reg[1:0], i_fsync};
			din_sync_reg  <= {din_sync_reg[1:0], i_din};
			if (bclk_sync_reg[1] == bclk_sync_reg[2]) begin
				bclk_reg <= bclk_sync_reg[2];
			end
			if (fs_sync_reg[1] == fs_sync_reg[2]) begin
				fs_reg <= fs_sync_reg[2];
			end
			if (din_sync_reg[1] == din_sync_reg[2]) begin
				din_reg <= din_sync_reg[2];
			end
		end
	end

	// a filtered bclk rise samples fsync and data; both are delayed alike
	assign bclk_rise   = (bclk_sync_reg[2] == bclk_sync_reg[1]) && bclk_sync_reg[2] && !bclk_reg;
	assign frame_start = bclk_rise && fs_reg && !fs_last_reg;
	assign right_start = bclk_rise && !i_fmt_tdm && !fs_reg && fs_last_reg;
	assign cap_ev      = bclk_rise && framed_reg && !frame_start && !right_start
		&& (bit_reg == srxr_pkg::LAST_BIT);
	assign serial_word = {shift_reg, din_reg};

	// key compared with each slot field: tdm slot, or half and slot in i2s/lj
	assign key = i_fmt_tdm ? slot_reg : {half_reg, slot_reg[3:0]};

	// bit and slot counters, restarted by each frame or half edge
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			fs_last_reg <= 1'b0;
			framed_reg  <= 1'b0;
			half_reg    <= 1'b0;
			bit_reg     <= 5'h00;
			slot_reg    <= 5'h00;
			shift_reg   <= 31'h0;
		end else if (bclk_rise) begin
			fs_last_reg <= fs_reg;
			shift_reg   <= serial_word[30:0];
			if (frame_start || right_start) begin
				framed_reg <= 1'b1;
				half_reg   <= right_start;
				bit_reg    <= 5'h01;
				slot_reg   <= 5'h00;
			end else if (bit_reg == srxr_pkg::LAST_BIT) begin
				bit_reg  <= 5'h00;
				slot_reg <= slot_reg + 5'h01; // wraps; slots past 31 alias
			end else begin
				bit_reg <= bit_reg + 5'h01;
			end
		end
	end

	// per channel slot match; disabled channels never hit
	always_comb begin
		cap_hit = 3'h0;
		for (int i = 0; i < srxr_pkg::NUM_CH; i++) begin
			cap_hit[i] = cap_ev && (src_of(i, cfg_reg[i]) != srxr_pkg::SRC_OFF)
				&& (cfg_reg[i][srxr_pkg::SLOT_MSB:0] == key);
		end
	end

	// lowest pending channel goes to the fifo first
	always_comb begin
		pop_sel = 3'h0;
		pop_idx = 2'h0;
		if (pend_reg[0]) begin
			pop_sel = 3'h1;
		end else if (pend_reg[1]) begin
			pop_sel = 3'h2;
			pop_idx = 2'h1;
		end else if (pend_reg[2]) begin
			pop_sel = 3'h4;
			pop_idx = 2'h2;
		end
		pop_sel = pop_sel & {3{fifo_ready}};
	end

	// holding words: a full fifo stalls here; a word lands only in a free holder
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pend_reg <= 3'h0;
		end else begin
			pend_reg <= cap_hit | (pend_reg & ~pop_sel);
		end
	end

	// sample source per channel; loopback and link words taken at slot end
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < srxr_pkg::NUM_CH; i++) begin
			if (cap_hit[i] && !(pend_reg[i] && !pop_sel[i])) begin
				unique case (src_of(i, cfg_reg[i]))
					srxr_pkg::SRC_ADC:
						word_reg[i] <= (i == 1) ? i_adc1_sample : i_adc2_sample;
					srxr_pkg::SRC_ICL: word_reg[i] <= i_icl_dev1_sample;
					default:           word_reg[i] <= serial_word;
				endcase
			end
		end
	end

	// sticky overrun; a new loss in the clear cycle keeps it set
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_overrun <= 1'b0;
		end else if (|(cap_hit & pend_reg & ~pop_sel)) begin
			o_overrun <= 1'b1;
		end else if (i_overrun_clr) begin
			o_overrun <= 1'b0;
		end
	end

	srxr_fifo #(
		.WIDTH (srxr_pkg::FIFO_W),
		.DEPTH (srxr_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (|pend_reg),
		.o_in_ready  (fifo_ready),
		.i_in_data   ({pop_idx, word_reg[pop_idx]}),
		.o_out_valid (o_dac_valid),
		.i_out_ready (i_dac_ready),
		.o_out_data  (fifo_out)
	);
	assign o_dac_chan = fifo_out[33:32];
	assign o_dac_data = fifo_out[31:0];

	// assertion helpers
	logic first_reg;
	always_ff @(posedge i_clk) begin
		first_reg <= !i_reset_n;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	rsvd_ch4_a: assert property (
		i_reg_addr == srxr_pkg::CH4_OFFSET |=> o_reg_rdata[7:6] == 2'h0)
		else $error("channel 4 reserved bits read nonzero");
	ch4_enable_a: assert property (
		cap_hit[0] |-> cfg_reg[0][5] ##1 pend_reg[0])
		else $error("channel 4 forwarded while not enabled");
	slot_left_a: assert property (
		cap_ev && !i_fmt_tdm && half_reg && cfg_reg[0][4:0] < 5'h10 |-> !cap_hit[0])
		else $error("low slot value hit a right half slot");
	slot_right_a: assert property (
		cap_ev && !i_fmt_tdm && !half_reg && cfg_reg[1][4] |-> !cap_hit[1])
		else $error("high slot value hit a left half slot");
	reset_vals_a: assert property (
		first_reg |-> cfg_reg[0] == 8'h03 && cfg_reg[1] == 8'h04
			&& cfg_reg[2] == 8'h05)
		else $error("register values after reset wrong");
	ch5_adc_a: assert property (
		cap_hit[1] && cfg_reg[1][6:5] == 2'h2 && !pend_reg[1]
			|=> word_reg[1] == $past(i_adc1_sample))
		else $error("channel 5 loopback word wrong");
	ch6_icl_a: assert property (
		cap_hit[2] && cfg_reg[2][6:5] == 2'h3 && !pend_reg[2]
			|=> word_reg[2] == $past(i_icl_dev1_sample))
		else $error("channel 6 link word wrong");
	rsvd_bit7_a: assert property (
		i_reg_addr == srxr_pkg::CH6_OFFSET ##1 1'b1 |-> o_reg_rdata[7] == 1'b0)
		else $error("channel 6 reserved bit reads one");
	disabled_nofwd_a: assert property (
		cap_ev && cfg_reg[1][6:5] inside {2'h0, 2'h3} && !pend_reg[1] |=> !pend_reg[1])
		else $error("disabled channel 5 forwarded a sample");

	cap_ch4_c: cover property (cap_hit[0] ##[1:40] o_dac_valid);
	multi_hit_c: cover property (cap_hit == 3'h7);
	fifo_full_c: cover property (|pend_reg && !fifo_ready);
endmodule // srxr_router

// ### verification/srxr_host_model.sv
// serial port controller model: drives bit clock, frame sync and data
// assumes the router samples on bit clock rise, msb first, 200 ns bit period
`timescale 1ns/1ps
module srxr_host_model (
	output logic o_bclk,
	output logic o_fsync,
	output logic o_din
);
	initial begin
		o_bclk = 1'b0;
		o_fsync = 1'b0;
		o_din = 1'b0;
	end

	// one frame; bit clock stands still outside it
	// tdm: nl slots; i2s/lj: nl left slots, nr right slots (keys 16 up)
	task automatic send_frame(input bit tdm, input int nl, input int nr,
			input logic [31:0] w [32]);
		int n;
		int key;
		#3.3; // phase unrelated to the system clock
		for (n = 0; n < (nl + nr) * 32; n++) begin
			key = (n / 32 < nl) ? n / 32 : 16 + n / 32 - nl;
			o_fsync = tdm ? (n == 0) : (n / 32 < nl);
			o_din = w[key][31 - n % 32];
			#100 o_bclk = 1'b1;
			#100 o_bclk = 1'b0;
		end
		o_fsync = 1'b0;
		o_din = ~o_din; // released line must not keep the last bit
	endtask
endmodule // srxr_host_model

// ### verification/serial_audio_rx_channel_router_tb.sv
// self-checking bench for the receive channel router
// assumes srxr_pkg, srxr_router and the host model are compiled first
`timescale 1ns/1ps
module serial_audio_rx_channel_router_tb;
	logic        i_clk, i_reset_n, i_reg_wr, i_fmt_tdm, i_dac_ready, i_overrun_clr;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic [31:0] i_adc1_sample, i_adc2_sample, i_icl_dev1_sample, o_dac_data;
	logic        o_dac_valid, o_overrun, bclk, fsync, din;
	logic [1:0]  o_dac_chan;
	logic [31:0] words [32];
	logic [33:0] expq [$];
	int          fail_count, compares;
	bit          stall, exp_ovr;

	srxr_router dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata),
		.i_fmt_tdm(i_fmt_tdm), .i_bclk(bclk), .i_fsync(fsync), .i_din(din),
		.i_adc1_sample(i_adc1_sample), .i_adc2_sample(i_adc2_sample),
		.i_icl_dev1_sample(i_icl_dev1_sample), .o_dac_valid(o_dac_valid),
		.i_dac_ready(i_dac_ready), .o_dac_data(o_dac_data), .o_dac_chan(o_dac_chan),
		.o_overrun(o_overrun), .i_overrun_clr(i_overrun_clr));
	srxr_host_model host (.o_bclk(bclk), .o_fsync(fsync), .o_din(din));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic fail(input string msg);
		$display("unexpected at %0t: %s", $time, msg);
		fail_count++;
	endtask

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1 i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(posedge i_clk);
		#1 i_reg_wr = 1'b0;
	endtask

	// read data is registered one cycle behind the address
	task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		#1 i_reg_addr = a;
		repeat (2) @(posedge i_clk);
		#1 compares++;
		if (o_reg_rdata !== e) fail("register read value");
	endtask

	task automatic check_word(input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e) fail("routed word or channel");
	endtask

	// random back-pressure, or a full stall while filling the buffer
	always begin
		@(posedge i_clk);
		#1 i_dac_ready = stall ? 1'b0 : 1'($urandom_range(1, 0));
	end

	// every accepted word is compared with the model queue
	always @(posedge i_clk) begin
		if (i_reset_n === 1'b1 && o_dac_valid === 1'b1 && i_dac_ready === 1'b1) begin
			if (expq.size() == 0) fail("word from no enabled channel");
			else check_word(expq.pop_front(), {o_dac_chan, o_dac_data});
		end
	end

	// program, predict, send one frame; holder plus fifo hold depth+1 words
	task automatic run_frame(input bit tdm, input int nl, input int nr,
			input logic [7:0] r4, input logic [7:0] r5, input logic [7:0] r6);
		logic [7:0]  r [3];
		logic [1:0]  code;
		logic [31:0] v;
		int          k;
		int          c;
		r = '{r4, r5, r6};
		wr(srxr_pkg::CH4_OFFSET, r4);
		wr(srxr_pkg::CH5_OFFSET, r5);
		wr(srxr_pkg::CH6_OFFSET, r6);
		i_fmt_tdm = tdm;
		foreach (words[i]) words[i] = $urandom;
		i_adc1_sample = $urandom;
		i_adc2_sample = $urandom;
		i_icl_dev1_sample = $urandom;
		for (k = 0; k < 32; k++) begin
			if (k < nl || (k >= 16 && k < 16 + nr)) begin
				for (c = 0; c < 3; c++) begin
					code = (c == 0) ? {1'b0, r[c][5]} : r[c][6:5];
					v = (code == 2'd1) ? words[k] : (c == 2 && code == 2'd3) ?
						i_icl_dev1_sample : (c == 1) ? i_adc1_sample : i_adc2_sample;
					if (code != 2'd0 && !(c == 1 && code == 2'd3) && r[c][4:0] == k) begin
						if (expq.size() > srxr_pkg::FIFO_DEPTH) exp_ovr = 1'b1;
						else expq.push_back({2'(c), v});
					end
				end
			end
		end
		host.send_frame(tdm, nl, nr, words);
		repeat (40) @(posedge i_clk);
		#1; // let the edge's pops and flag updates settle first
		if (!stall) begin
			compares++;
			if (expq.size() != 0) fail("routed word missing");
		end
	endtask

	initial begin
		{i_reset_n, i_reg_wr, i_fmt_tdm, i_dac_ready, i_overrun_clr} = '0;
		{i_reg_addr, i_reg_wdata} = '0;
		{i_adc1_sample, i_adc2_sample, i_icl_dev1_sample} = '0;
		void'($urandom(32'ha6d5));
		repeat (6) @(posedge i_clk);
		#1 i_reset_n = 1'b1;
		check_reg(srxr_pkg::CH4_OFFSET, 8'h03);
		check_reg(srxr_pkg::CH5_OFFSET, 8'h04);
		check_reg(srxr_pkg::CH6_OFFSET, 8'h05);
		check_reg(8'h2e, 8'h00);
		$display("test reset values done");
		// reserved bits dropped, unmapped write ignored
		wr(srxr_pkg::CH4_OFFSET, 8'hff);
		wr(srxr_pkg::CH5_OFFSET, 8'hff);
		wr(srxr_pkg::CH6_OFFSET, 8'hff);
		wr(8'h2e, 8'h11);
		check_reg(srxr_pkg::CH4_OFFSET, 8'h3f);
		check_reg(srxr_pkg::CH5_OFFSET, 8'h7f);
		check_reg(srxr_pkg::CH6_OFFSET, 8'h7f);
		check_reg(8'h2e, 8'h00);
		$display("test reserved bits done");
		// every source code, tdm and i2s/lj slot keys
		run_frame(1, 32, 0, {3'b001, 5'($urandom)}, {3'b001, 5'($urandom)},
			{3'b001, 5'($urandom)});
		run_frame(1, 8, 0, 8'h03, {3'b010, 5'($urandom_range(7, 0))},
			{3'b010, 5'($urandom_range(7, 0))});
		run_frame(1, 8, 0, {3'b001, 5'($urandom_range(7, 0))}, 8'h62,
			{3'b011, 5'($urandom_range(7, 0))});
		run_frame(0, 16, 16, {3'b001, 5'($urandom)}, {3'b001, 5'($urandom)},
			{3'b010, 5'($urandom)});
		run_frame(0, 3, 2, 8'h31, 8'h11, 8'h21);
		$display("test routing done");
		// fill until the holder is refused, then drain
		stall = 1'b1;
		repeat (10) run_frame(1, 4, 0, 8'h23, 8'h04, 8'h05);
		compares++;
		if (o_overrun !== exp_ovr) fail("lost capture not flagged");
		stall = 1'b0;
		repeat (100) @(posedge i_clk);
		#1 compares++;
		if (expq.size() != 0) fail("buffered words not drained");
		@(posedge i_clk);
		#1 i_overrun_clr = 1'b1;
		@(posedge i_clk);
		#1 i_overrun_clr = 1'b0;
		@(posedge i_clk);
		#1 compares++;
		if (o_overrun !== 1'b0) fail("overrun flag not cleared");
		$display("test buffer stall done");
		test_done();
	end

	// run needs about 0.8 ms; cut a hang well beyond that
	initial begin
		#2000000;
		fail("watchdog expired");
		test_done();
	end
endmodule // serial_audio_rx_channel_router_tb
